// file: logic/dsof_pkg.sv
/*
  Package for the drive status output flag block: register offsets, field
  positions, reset values and option codes of the selectable flags.
  Assumes a Wishbone classic slave with 32-bit data and byte addressing.
*/
package dsof_pkg;

  // ********************************************************
  // Register byte offsets.
  // ********************************************************
  localparam logic [7:0] DSOF_OFS_CTRL    = 8'h00;
  localparam logic [7:0] DSOF_OFS_OHLVL   = 8'h04;
  localparam logic [7:0] DSOF_OFS_LLLVL   = 8'h08;
  localparam logic [7:0] DSOF_OFS_VWIN    = 8'h0C;
  localparam logic [7:0] DSOF_OFS_CWIN    = 8'h10;
  localparam logic [7:0] DSOF_OFS_SEL     = 8'h14;
  localparam logic [7:0] DSOF_OFS_FLAGS   = 8'h18;
  localparam logic [7:0] DSOF_OFS_IRQSTAT = 8'h1C;
  localparam logic [7:0] DSOF_OFS_IRQMASK = 8'h20;

  // ********************************************************
  // Field positions.
  // ********************************************************
  localparam int DSOF_CTRL_UP0   = 0;
  localparam int DSOF_CTRL_UP2   = 2;
  localparam int DSOF_CTRL_LLM   = 3;
  localparam int DSOF_WIN_MAX_LO = 16;
  localparam int DSOF_SEL_T2_LO  = 8;
  localparam int DSOF_SEL_RL_LO  = 16;

  // ********************************************************
  // Reset values.
  // ********************************************************
  localparam logic [15:0] DSOF_RST_OHLVL = 16'h0FFF;
  localparam logic [15:0] DSOF_RST_LLLVL = 16'h0000;
  localparam logic [31:0] DSOF_RST_WIN   = 32'hFFFF_0000;
  localparam logic [7:0]  DSOF_RST_SEL   = 8'h00;

  // ********************************************************
  // Option codes and flag vector layout.
  // ********************************************************
  localparam int DSOF_NFLAG = 12;
  localparam logic [7:0] DSOF_OPT_OHW = 8'h2A;
  localparam logic [7:0] DSOF_OPT_LLF = 8'h2B;
  localparam logic [7:0] DSOF_OPT_UP1 = 8'h2C;
  localparam logic [7:0] DSOF_OPT_UP2 = 8'h2D;
  localparam logic [7:0] DSOF_OPT_UP3 = 8'h2E;
  localparam logic [7:0] DSOF_OPT_RDY = 8'h32;
  localparam logic [7:0] DSOF_OPT_FWD = 8'h33;
  localparam logic [7:0] DSOF_OPT_REV = 8'h34;
  localparam logic [7:0] DSOF_OPT_MJF = 8'h35;
  localparam logic [7:0] DSOF_OPT_VWF = 8'h36;
  localparam logic [7:0] DSOF_OPT_CWF = 8'h37;

  // Run direction commanded to the power stage.
  typedef enum logic [1:0] {
    DSOF_RUN_STOP = 2'b00,
    DSOF_RUN_FWD  = 2'b01,
    DSOF_RUN_REV  = 2'b10
  } dsof_run_type;

  // Measurements presented by the drive core.
  typedef struct packed {
    logic [15:0] heatsink_temp;
    logic [15:0] output_current;
    logic [15:0] voltage_analog_input;
    logic [15:0] current_analog_input;
  } dsof_meas_type;

endpackage

// file: logic/dsof_top.sv
/*
  Drive status output flags: compares measurements with software limits,
  keeps the run state, and routes the selected flags to two open-collector
  terminals and a relay. Assumes measurements and commands come from logic
  on sys_clk_i; only the hardware fault input is treated as asynchronous.
*/
// Implementation choices: the register addresses and register access over Wishbone.
module dsof_top
  import dsof_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire dsof_meas_type meas_i,
  input  wire logic          power_ok_i,
  input  wire logic          cmd_fwd_i,
  input  wire logic          cmd_rev_i,
  input  wire logic          cmd_stop_i,
  input  wire logic          soft_trip_i,
  input  wire logic          hw_fault_i,
  input  wire logic          trip_reset_i,
  output logic [1:0]         run_dir_o,
  output logic               alarm_o,
  output logic               term1_oe_n_o,
  output logic               term2_oe_n_o,
  output logic               relay_o,
  output logic               irq_o
);

  // ********************************************************
  // Register bus.
  // ********************************************************
  logic [3:0]            ctrl_ff;
  logic [15:0]           ohlvl_ff;
  logic [15:0]           lllvl_ff;
  logic [31:0]           vwin_ff;
  logic [31:0]           cwin_ff;
  logic [23:0]           sel_ff;
  logic [DSOF_NFLAG-1:0] irq_stat_ff;
  logic [DSOF_NFLAG-1:0] irq_mask_ff;
  logic [DSOF_NFLAG-1:0] flags_ff;
  logic [DSOF_NFLAG-1:0] flags_q_ff;
  logic [31:0]           nxt_rdata;
  logic                  wr_stb;

  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  // One wait state: ack rises the cycle after the strobe and drops after.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) wb_dat_o <= nxt_rdata;
    end
  end

  // Merges the written byte lanes into a register; other lanes keep value.
  function automatic logic [31:0] dsof_lanes(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) r[b*8 +: 8] = wb_dat_i[b*8 +: 8];
    end
    return r;
  endfunction

  // Configuration writes. Byte lanes are honoured for every register except
  // the control register, whose small fields use lane 0 alone.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_ff     <= 4'h0;
      ohlvl_ff    <= DSOF_RST_OHLVL;
      lllvl_ff    <= DSOF_RST_LLLVL;
      vwin_ff     <= DSOF_RST_WIN;
      cwin_ff     <= DSOF_RST_WIN;
      sel_ff      <= {DSOF_RST_SEL, DSOF_RST_SEL, DSOF_RST_SEL};
      irq_mask_ff <= '0;
    end else if (wr_stb) begin
      case (wb_adr_i)
        DSOF_OFS_CTRL: if (wb_sel_i[0]) ctrl_ff <= wb_dat_i[3:0];
        DSOF_OFS_OHLVL: ohlvl_ff <= 16'(dsof_lanes({16'h0, ohlvl_ff}));
        DSOF_OFS_LLLVL: lllvl_ff <= 16'(dsof_lanes({16'h0, lllvl_ff}));
        DSOF_OFS_VWIN: vwin_ff <= dsof_lanes(vwin_ff);
        DSOF_OFS_CWIN: cwin_ff <= dsof_lanes(cwin_ff);
        DSOF_OFS_SEL: sel_ff <= 24'(dsof_lanes({8'h0, sel_ff}));
        DSOF_OFS_IRQMASK: irq_mask_ff <= 12'(dsof_lanes({20'h0, irq_mask_ff}));
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero and still get an ack.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      DSOF_OFS_CTRL:    nxt_rdata = {28'h0, ctrl_ff};
      DSOF_OFS_OHLVL:   nxt_rdata = {16'h0, ohlvl_ff};
      DSOF_OFS_LLLVL:   nxt_rdata = {16'h0, lllvl_ff};
      DSOF_OFS_VWIN:    nxt_rdata = vwin_ff;
      DSOF_OFS_CWIN:    nxt_rdata = cwin_ff;
      DSOF_OFS_SEL:     nxt_rdata = {8'h0, sel_ff};
      DSOF_OFS_FLAGS:   nxt_rdata = {20'h0, flags_ff};
      DSOF_OFS_IRQSTAT: nxt_rdata = {20'h0, irq_stat_ff};
      DSOF_OFS_IRQMASK: nxt_rdata = {20'h0, irq_mask_ff};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // ********************************************************
  // Hardware fault synchroniser and trip state.
  // ********************************************************
  logic hw_meta_ff;
  logic hw_sync_ff;
  logic alarm_ff;
  logic major_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hw_meta_ff <= 1'b0;
      hw_sync_ff <= 1'b0;
    end else begin
      hw_meta_ff <= hw_fault_i;
      hw_sync_ff <= hw_meta_ff;
    end
  end

  // A trip latches until reset; a new cause in the reset cycle wins.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_ff <= 1'b0;
      major_ff <= 1'b0;
    end else begin
      if (hw_sync_ff || soft_trip_i) begin
        alarm_ff <= 1'b1;
      end else if (trip_reset_i) begin
        alarm_ff <= 1'b0;
      end
      if (hw_sync_ff) begin
        major_ff <= 1'b1;
      end else if (trip_reset_i && !soft_trip_i) begin
        major_ff <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Run state machine.
  // ********************************************************
  dsof_run_type run_ff;
  dsof_run_type nxt_run;
  logic         ready;

  // Ready only with good mains and no latched trip.
  assign ready = power_ok_i && !alarm_ff;

  always_comb begin
    nxt_run = run_ff;
    case (run_ff)
      DSOF_RUN_STOP, DSOF_RUN_FWD, DSOF_RUN_REV: begin
        if (!ready) begin
          nxt_run = DSOF_RUN_STOP;
        end else if (cmd_stop_i || (cmd_fwd_i && cmd_rev_i)) begin
          nxt_run = DSOF_RUN_STOP;
        end else if (cmd_fwd_i) begin
          nxt_run = DSOF_RUN_FWD;
        end else if (cmd_rev_i) begin
          nxt_run = DSOF_RUN_REV;
        end
      end
      default: nxt_run = DSOF_RUN_STOP;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_ff <= DSOF_RUN_STOP;
    end else begin
      run_ff <= nxt_run;
    end
  end

  assign run_dir_o = run_ff;
  assign alarm_o   = alarm_ff;

  // ********************************************************
  // Flag evaluation.
  // ********************************************************
  logic [DSOF_NFLAG-1:0] nxt_flags;
  logic                  ll_active;

  // Light-load mode bit set limits detection to running.
  assign ll_active = !ctrl_ff[DSOF_CTRL_LLM] || (run_ff != DSOF_RUN_STOP);

  always_comb begin
    nxt_flags     = '0;
    nxt_flags[0]  = meas_i.heatsink_temp > ohlvl_ff;
    nxt_flags[1]  = ll_active && (meas_i.output_current < lllvl_ff);
    nxt_flags[4:2] = ctrl_ff[DSOF_CTRL_UP2:DSOF_CTRL_UP0];
    nxt_flags[5]  = ready;
    nxt_flags[6]  = run_ff == DSOF_RUN_FWD;
    nxt_flags[7]  = run_ff == DSOF_RUN_REV;
    nxt_flags[8]  = major_ff;
    nxt_flags[9]  = (meas_i.voltage_analog_input >= vwin_ff[15:0]) &&
                    (meas_i.voltage_analog_input <=
                     vwin_ff[DSOF_WIN_MAX_LO +: 16]);
    nxt_flags[10] = (meas_i.current_analog_input >= cwin_ff[15:0]) &&
                    (meas_i.current_analog_input <=
                     cwin_ff[DSOF_WIN_MAX_LO +: 16]);
    nxt_flags[11] = alarm_ff;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_ff   <= '0;
      flags_q_ff <= '0;
    end else begin
      flags_ff   <= nxt_flags;
      flags_q_ff <= flags_ff;
    end
  end

  // ********************************************************
  // Output routing.
  // ********************************************************
  // Option code of each flag bit; the alarm bit has none and is not routed.
  localparam logic [7:0] OPT_CODE [DSOF_NFLAG-1] = '{DSOF_OPT_OHW,
    DSOF_OPT_LLF, DSOF_OPT_UP1, DSOF_OPT_UP2, DSOF_OPT_UP3, DSOF_OPT_RDY,
    DSOF_OPT_FWD, DSOF_OPT_REV, DSOF_OPT_MJF, DSOF_OPT_VWF, DSOF_OPT_CWF};
  function automatic logic dsof_pick(input logic [7:0] code,
                                     input logic [DSOF_NFLAG-1:0] f);
    logic r;
    r = 1'b0;
    for (int k = 0; k < DSOF_NFLAG - 1; k++) begin
      if (code == OPT_CODE[k]) r = f[k];
    end
    return r;
  endfunction

  // Open collector: a set flag sinks current, so enable is low then.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      term1_oe_n_o <= 1'b1;
      term2_oe_n_o <= 1'b1;
      relay_o      <= 1'b0;
    end else begin
      term1_oe_n_o <= !dsof_pick(sel_ff[7:0], flags_ff);
      term2_oe_n_o <= !dsof_pick(sel_ff[DSOF_SEL_T2_LO +: 8], flags_ff);
      relay_o      <= dsof_pick(sel_ff[DSOF_SEL_RL_LO +: 8], flags_ff);
    end
  end

  // ********************************************************
  // Interrupts: rising flag edges, write-one-to-clear, set wins.
  // ********************************************************
  logic [DSOF_NFLAG-1:0] rise;
  logic [DSOF_NFLAG-1:0] clr;

  assign rise = flags_ff & ~flags_q_ff;
  assign clr  = (wr_stb && wb_adr_i == DSOF_OFS_IRQSTAT) ?
                (wb_dat_i[DSOF_NFLAG-1:0] &
                 {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) : '0;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | rise;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ********************************************************
  // Checks.
  // ********************************************************
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  chk_overheat_flag: assert property (
    flags_ff[0] == ($past(meas_i.heatsink_temp) > $past(ohlvl_ff)))
    else $error("overheat flag wrong");
  chk_user_out: assert property (
    flags_ff[4:2] == $past(ctrl_ff[2:0]))
    else $error("user output mismatch");
  chk_not_ready_stop: assert property (
    !ready |=> run_ff == DSOF_RUN_STOP)
    else $error("ran while not ready");
  chk_fwd_flag: assert property (
    run_ff == DSOF_RUN_FWD |=> flags_ff[6] && !flags_ff[7])
    else $error("forward flag wrong");
  chk_stop_flags: assert property (
    run_ff != DSOF_RUN_FWD |=> !flags_ff[6])
    else $error("forward flag not cleared");
  chk_rev_flag: assert property (
    run_ff == DSOF_RUN_REV |=> flags_ff[7] && !flags_ff[6])
    else $error("reverse flag wrong");
  chk_major_alarm: assert property (
    hw_sync_ff |=> major_ff && alarm_ff)
    else $error("hardware trip not flagged");
  chk_soft_trip: assert property (
    soft_trip_i && !hw_sync_ff && !major_ff |=> alarm_ff && !major_ff)
    else $error("soft trip raised major");
  chk_term1_route: assert property (
    sel_ff[7:0] == DSOF_OPT_RDY && $stable(sel_ff) |=>
    term1_oe_n_o == !$past(flags_ff[5]))
    else $error("terminal 1 routing");

  cov_fwd_run: cover property (@(posedge sys_clk_i) run_ff == DSOF_RUN_FWD);
  cov_rev_run: cover property (@(posedge sys_clk_i) run_ff == DSOF_RUN_REV);
  cov_major:   cover property (@(posedge sys_clk_i) major_ff);
  cov_irq:     cover property (@(posedge sys_clk_i) irq_o);

endmodule

// file: testbench/dsof_term_model.sv
/*
  Model of the external controller that reads the two open-collector
  terminals and the relay contact of the drive status output block.
  Assumes each terminal line has a pull-up at the controller side.
*/
module dsof_term_model
  import dsof_pkg::*;
(
  input  wire logic term1_oe_n_i,
  input  wire logic term2_oe_n_i,
  input  wire logic relay_i,
  output logic      line1_o,
  output logic      line2_o,
  output logic      contact_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************
  // Line levels seen by the controller.
  // ********************************************************
  // A released collector floats up to the pull-up, so only a firm low
  // enable sinks the line; an unknown enable reads as released.
  assign line1_o = (term1_oe_n_i === 1'b0) ? 1'b0 : 1'b1;
  assign line2_o = (term2_oe_n_i === 1'b0) ? 1'b0 : 1'b1;
  // The contact closes only while the coil is firmly energised.
  assign contact_o = (relay_i === 1'b1) ? 1'b1 : 1'b0;
endmodule

// file: testbench/testbench.sv
/*
  Self-checking bench for the drive status output flag block: register
  access over classic Wishbone, measurement and command stimulus, and
  checks of flags, run state, trips, routing and the interrupt.
  Assumes a 250 MHz clock and the terminal model beside the block.
*/
module testbench
  import dsof_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************
  // Stimulus and observation signals.
  // ********************************************************
  logic          sys_clk_i    = 1'b0;
  logic          rstn_i       = 1'b0;
  logic          wb_cyc_i     = 1'b0;
  logic          wb_stb_i     = 1'b0;
  logic          wb_we_i      = 1'b0;
  logic [7:0]    wb_adr_i     = 8'h00;
  logic [3:0]    wb_sel_i     = 4'hF;
  logic [31:0]   wb_dat_i     = 32'h0000_0000;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  dsof_meas_type meas_i       = '0;
  logic          power_ok_i   = 1'b0;
  logic          cmd_fwd_i    = 1'b0;
  logic          cmd_rev_i    = 1'b0;
  logic          cmd_stop_i   = 1'b0;
  logic          soft_trip_i  = 1'b0;
  logic          hw_fault_i   = 1'b0;
  logic          trip_reset_i = 1'b0;
  logic [1:0]    run_dir_o;
  logic          alarm_o;
  logic          term1_oe_n_o;
  logic          term2_oe_n_o;
  logic          relay_o;
  logic          irq_o;
  logic          line1;
  logic          line2;
  logic          contact;
  int            miscompares  = 0;
  int            check_count  = 0;
  logic [31:0]   q;
  logic [7:0]    codes [11] = '{DSOF_OPT_OHW, DSOF_OPT_LLF, DSOF_OPT_UP1,
    DSOF_OPT_UP2, DSOF_OPT_UP3, DSOF_OPT_RDY, DSOF_OPT_FWD, DSOF_OPT_REV,
    DSOF_OPT_MJF, DSOF_OPT_VWF, DSOF_OPT_CWF};

  // Clock of 4 ns period.
  always #2 sys_clk_i = ~sys_clk_i;

  dsof_top u_dsof_top (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meas_i(meas_i), .power_ok_i(power_ok_i),
    .cmd_fwd_i(cmd_fwd_i), .cmd_rev_i(cmd_rev_i), .cmd_stop_i(cmd_stop_i),
    .soft_trip_i(soft_trip_i), .hw_fault_i(hw_fault_i),
    .trip_reset_i(trip_reset_i), .run_dir_o(run_dir_o), .alarm_o(alarm_o),
    .term1_oe_n_o(term1_oe_n_o), .term2_oe_n_o(term2_oe_n_o),
    .relay_o(relay_o), .irq_o(irq_o));

  dsof_term_model u_dsof_term_model (
    .term1_oe_n_i(term1_oe_n_o), .term2_oe_n_i(term2_oe_n_o),
    .relay_i(relay_o), .line1_o(line1), .line2_o(line2),
    .contact_o(contact));

  // ********************************************************
  // Shared tasks.
  // ********************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      miscompares++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(32'(wb_ack_o), 32'h1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbx(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wbx(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // Measurements change together, then settle past the flag pipeline.
  task automatic setm(input logic [15:0] t, c, v, i);
    @(posedge sys_clk_i);
    meas_i <= '{t, c, v, i};
    tick(4);
  endtask

  // One-cycle command pulse on forward, reverse and stop.
  task automatic cmd(input logic [2:0] c);
    @(posedge sys_clk_i);
    {cmd_fwd_i, cmd_rev_i, cmd_stop_i} <= c;
    @(posedge sys_clk_i);
    {cmd_fwd_i, cmd_rev_i, cmd_stop_i} <= 3'b000;
    tick(4);
  endtask

  // Trip inputs held at a level; the wait covers the fault synchroniser.
  task automatic trip(input logic [2:0] v);
    @(posedge sys_clk_i);
    {soft_trip_i, hw_fault_i, trip_reset_i} <= v;
    tick(6);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // The whole sequence needs a few hundred cycles; this cuts a hang.
  initial begin
    tick(20000);
    miscompares++;
    give_verdict;
  end

  // ********************************************************
  // Test sequence.
  // ********************************************************
  initial begin
    tick(12);
    rstn_i <= 1'b1;
    tick(1);
    rdc(DSOF_OFS_FLAGS, 32'h600);
    rdc(DSOF_OFS_OHLVL, 32'h0FFF);
    rdc(DSOF_OFS_LLLVL, 32'h0);
    rdc(DSOF_OFS_VWIN, DSOF_RST_WIN);
    rdc(DSOF_OFS_CWIN, DSOF_RST_WIN);
    rdc(DSOF_OFS_SEL, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    // Strict comparisons: equal to the level gives no flag.
    wr(DSOF_OFS_OHLVL, 32'h100);
    setm(16'h100, 16'h0, 16'h0, 16'h0);
    rdc(DSOF_OFS_FLAGS, 32'h600);
    setm(16'h101, 16'h0, 16'h0, 16'h0);
    rdc(DSOF_OFS_FLAGS, 32'h601);
    wr(DSOF_OFS_LLLVL, 32'h50);
    setm(16'h0, 16'h50, 16'h0, 16'h0);
    rdc(DSOF_OFS_FLAGS, 32'h600);
    setm(16'h0, 16'h4F, 16'h0, 16'h0);
    rdc(DSOF_OFS_FLAGS, 32'h602);
    // Window edges are inside, one step beyond is outside.
    wr(DSOF_OFS_VWIN, 32'h0020_0010);
    wr(DSOF_OFS_CWIN, 32'h0020_0010);
    setm(16'h0, 16'h50, 16'h10, 16'h20);
    rdc(DSOF_OFS_FLAGS, 32'h600);
    setm(16'h0, 16'h50, 16'h21, 16'h0F);
    rdc(DSOF_OFS_FLAGS, 32'h000);
    setm(16'h0, 16'h50, 16'h0F, 16'h21);
    rdc(DSOF_OFS_FLAGS, 32'h000);
    wr(DSOF_OFS_CTRL, 32'h5);
    rdc(DSOF_OFS_FLAGS, 32'h014);
    // Commands while not ready are dropped.
    cmd(3'b100);
    chk(32'(run_dir_o), 32'(DSOF_RUN_STOP));
    rdc(DSOF_OFS_FLAGS, 32'h014);
    @(posedge sys_clk_i);
    power_ok_i <= 1'b1;
    tick(4);
    rdc(DSOF_OFS_FLAGS, 32'h034);
    cmd(3'b100);
    chk(32'(run_dir_o), 32'(DSOF_RUN_FWD));
    rdc(DSOF_OFS_FLAGS, 32'h074);
    cmd(3'b010);
    chk(32'(run_dir_o), 32'(DSOF_RUN_REV));
    rdc(DSOF_OFS_FLAGS, 32'h0B4);
    cmd(3'b001);
    rdc(DSOF_OFS_FLAGS, 32'h034);
    cmd(3'b100);
    cmd(3'b110);
    chk(32'(run_dir_o), 32'(DSOF_RUN_STOP));
    // A soft trip while running: alarm only, ready drops, motor stops.
    cmd(3'b100);
    trip(3'b100);
    trip(3'b000);
    chk(32'(alarm_o), 32'h1);
    rdc(DSOF_OFS_FLAGS, 32'h814);
    trip(3'b001);
    trip(3'b000);
    chk(32'(alarm_o), 32'h0);
    trip(3'b010);
    chk(32'(alarm_o), 32'h1);
    rdc(DSOF_OFS_FLAGS, 32'h914);
    trip(3'b000);
    trip(3'b001);
    trip(3'b000);
    chk(32'(alarm_o), 32'h0);
    // Every code routed to all three outputs against a known flag set.
    cmd(3'b100);
    setm(16'h101, 16'h4F, 16'h10, 16'h30);
    rdc(DSOF_OFS_FLAGS, 32'h277);
    for (int k = 0; k < 11; k++) begin
      wr(DSOF_OFS_SEL, {8'h00, codes[k], codes[k], codes[k]});
      tick(3);
      chk(32'(line1), 32'(!q[k]));
      chk(32'(line2), 32'(!q[k]));
      chk(32'(contact), 32'(q[k]));
    end
    wr(DSOF_OFS_SEL, {8'h00, DSOF_OPT_REV, DSOF_OPT_FWD, DSOF_OPT_OHW});
    cmd(3'b010);
    chk({29'h0, line1, line2, contact}, 32'h3);
    wr(DSOF_OFS_SEL, 32'h0);
    tick(3);
    chk({29'h0, line1, line2, contact}, 32'h6);
    // Interrupt: sticky on a rising flag, masked, then cleared.
    wr(DSOF_OFS_IRQMASK, 32'hFFE);
    setm(16'h0, 16'h4F, 16'h10, 16'h30);
    wr(DSOF_OFS_IRQSTAT, 32'hFFF);
    rdc(DSOF_OFS_IRQSTAT, 32'h0);
    setm(16'h101, 16'h4F, 16'h10, 16'h30);
    rdc(DSOF_OFS_IRQSTAT, 32'h1);
    chk(32'(irq_o), 32'h0);
    wr(DSOF_OFS_IRQMASK, 32'h001);
    tick(2);
    chk(32'(irq_o), 32'h1);
    wr(DSOF_OFS_IRQSTAT, 32'h1);
    tick(2);
    chk(32'(irq_o), 32'h0);
    rdc(DSOF_OFS_IRQSTAT, 32'h0);
    give_verdict;
  end

  // Routing expectations are the flag set the bench itself set up.
  assign q = 32'h277;
endmodule
